// *** design/fsr_map.svh ***
// offsets, codes and counts of the flash settings readback
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
`define FSR_RSP_BYTES 7'h40
`define FSR_LAST_IDX 6'h3f
`define FSR_CMD_ECHO 8'hb0
`define FSR_STS_OK 8'h00
`define FSR_CHIP_LEN 8'h0e
`define FSR_GP_LEN 8'h08
`define FSR_IX_CMD 6'h00
`define FSR_IX_STS 6'h01
`define FSR_IX_LEN 6'h02
`define FSR_IX_CFG7 6'h07
`define FSR_IX_VID_LO 6'h08
`define FSR_IX_VID_HI 6'h09
`define FSR_IX_PID_LO 6'h0a
`define FSR_IX_PID_HI 6'h0b
`define FSR_IX_PWR 6'h0c
`define FSR_IX_MA 6'h0d
`define FSR_IX_PIN_A 6'h04
`define FSR_IX_PIN_D 6'h07
`define FSR_DES_GPIO 3'h0
`define FSR_DES_F1 3'h1
`define FSR_DES_F2 3'h2
`define FSR_DES_F3 3'h3
`define FSR_DES_F4 3'h4
`define FSR_PIN_A 2'h0
`define FSR_PIN_B 2'h1
`define FSR_PIN_C 2'h2
`define FSR_PIN_D 2'h3
`endif

// *** design/fsr_pkg.sv ***
// types shared by the flash settings readback
package fsr_pkg;
	// one pin's stored power-up byte, low five bits
	typedef struct packed {
		logic out_level;
		logic dir_in;
		logic [2:0] desig;
	} fsr_pin_cfg_t;
	// stored chip settings covered by this block
	typedef struct packed {
		logic neg_en;
		logic pos_en;
		logic [1:0] adc_ref;
		logic dac_supply;
		logic [15:0] vid;
		logic [15:0] pid;
		logic [7:0] pwr_attr;
		logic [7:0] half_ma;
	} fsr_chip_cfg_t;
	// indicator sources for pins in a dedicated role
	typedef struct packed {
		logic suspend;
		logic urx_act;
		logic utx_act;
		logic clk_ref;
		logic usb_cfg;
		logic i2c_act;
	} fsr_alt_t;
	// analog converter reference choice, in stored code order
	typedef enum logic [1:0] {FSR_REF_OFF, FSR_REF_1V024, FSR_REF_2V048, FSR_REF_4V096} fsr_adc_ref_t;
	// pin role after decode
	typedef enum logic [3:0] {
		FSR_FN_GPIO, FSR_FN_SUSPEND, FSR_FN_URX, FSR_FN_CLKREF, FSR_FN_ANALOG_INPUT_ONE,
		FSR_FN_UTX, FSR_FN_EDGE, FSR_FN_USB_CONFIGURED_INDICATOR, FSR_FN_ANALOG_INPUT_TWO, FSR_FN_ANALOG_OUTPUT_ONE,
		FSR_FN_I2C, FSR_FN_ADC3, FSR_FN_DAC2, FSR_FN_NONE
	} fsr_func_t;
	typedef enum logic [1:0] {FSR_ST_APPLY, FSR_ST_IDLE, FSR_ST_SEND} fsr_state_t;
endpackage

// *** design/fsr_top.sv ***
// read-flash-data response builder and power-up pin applier
//
// Contract
// RQ1: byte zero echoes command, byte one zero
// RQ2: negative-edge enable sets interrupt detection flag
// RQ3: positive-edge enable sets interrupt detection flag
// RQ4: bits four-three pick analog converter reference
// RQ5: bit two: supply or internal output reference
// RQ6: vendor id low byte first, bytes 8-9
// RQ7: product id low byte first, bytes 10-11
// RQ8: power attributes byte reported at enumeration
// RQ9: requested current is twice stored value
// RQ10: pin a bit four is power-up level
// RQ11: pins b, c level in bit four
// RQ12: bit three input, only in general-purpose mode
// RQ13: pin a designation codes, rest ignored
// RQ14: pin b designation codes, rest ignored
// RQ15: pin c designation codes, rest ignored
// RQ16: byte seven carries pin d, same layout
// RQ17: always full 64-byte report, filler after
// RQ18: stored pin setup applied before any command
`timescale 1ns/10ps
`include "fsr_map.svh"
module fsr_top
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce, // freezes all state while low
	input wire fsr_pkg::fsr_chip_cfg_t chip_cfg_i, // stored chip settings
	input wire fsr_pkg::fsr_pin_cfg_t [3:0] pin_cfg_i, // stored pin bytes, 0=a .. 3=d
	input wire fsr_pkg::fsr_alt_t alt_i, // indicator sources
	input wire logic req_valid, // read request, one cycle
	input wire logic req_gp, // 1 pin settings, 0 chip settings
	output logic req_ready_q,
	output logic rsp_valid_q,
	output logic [7:0] rsp_data_q,
	output logic [5:0] rsp_index_q,
	output logic rsp_last_q,
	input wire logic [3:0] general_pin_i,
	output logic [3:0] general_pin_o_q,
	output logic [3:0] general_pin_oe_q,
	output fsr_pkg::fsr_func_t [3:0] pin_func_q,
	input wire logic intr_clear, // clears interrupt detection flag
	output logic intr_flag_q,
	output fsr_pkg::fsr_adc_ref_t adc_ref_q,
	output logic dac_ref_supply_q,
	output logic [7:0] usb_pwr_attr_q,
	output logic [8:0] usb_max_ma_q
);
	fsr_pkg::fsr_state_t state_q; // sequencer state
	logic [5:0] idx_q; // next byte to emit
	logic kind_q; // latched request kind
	logic [2:0] edge_sync_q; // pin b input chain
	logic rise; // rising edge after sync
	logic fall; // falling edge after sync
	logic take; // request accepted

	// decode a pin's stored designation into its role
	function automatic fsr_pkg::fsr_func_t decode_fn(input logic [1:0] pin, input logic [2:0] d);
		fsr_pkg::fsr_func_t f;
		f = fsr_pkg::FSR_FN_NONE;
		if (d == `FSR_DES_GPIO)
		begin
			f = fsr_pkg::FSR_FN_GPIO;
		end
		else
		begin
			unique case (pin)
				// pin a roles
				`FSR_PIN_A:
				begin
					if (d == `FSR_DES_F1) f = fsr_pkg::FSR_FN_SUSPEND;
					else if (d == `FSR_DES_F2) f = fsr_pkg::FSR_FN_URX;
				end
				// pin b roles
				`FSR_PIN_B:
				begin
					if (d == `FSR_DES_F1) f = fsr_pkg::FSR_FN_CLKREF;
					else if (d == `FSR_DES_F2) f = fsr_pkg::FSR_FN_ANALOG_INPUT_ONE;
					else if (d == `FSR_DES_F3) f = fsr_pkg::FSR_FN_UTX;
					else if (d == `FSR_DES_F4) f = fsr_pkg::FSR_FN_EDGE;
				end
				// pin c roles
				`FSR_PIN_C:
				begin
					if (d == `FSR_DES_F1) f = fsr_pkg::FSR_FN_USB_CONFIGURED_INDICATOR;
					else if (d == `FSR_DES_F2) f = fsr_pkg::FSR_FN_ANALOG_INPUT_TWO;
					else if (d == `FSR_DES_F3) f = fsr_pkg::FSR_FN_ANALOG_OUTPUT_ONE;
				end
				// pin d roles
				`FSR_PIN_D:
				begin
					if (d == `FSR_DES_F1) f = fsr_pkg::FSR_FN_I2C;
					else if (d == `FSR_DES_F2) f = fsr_pkg::FSR_FN_ADC3;
					else if (d == `FSR_DES_F3) f = fsr_pkg::FSR_FN_DAC2;
				end
			endcase
		end
		return f;
	endfunction

	// response byte at an index; reads the live stored image
	function automatic logic [7:0] rsp_byte(input logic gp, input logic [5:0] i,
		input fsr_pkg::fsr_chip_cfg_t c, input fsr_pkg::fsr_pin_cfg_t [3:0] p);
		logic [7:0] b;
		b = 8'h00;
		// RQ1: header bytes
		if (i == `FSR_IX_CMD) b = `FSR_CMD_ECHO;
		else if (i == `FSR_IX_STS) b = `FSR_STS_OK;
		else if (i == `FSR_IX_LEN) b = gp ? `FSR_GP_LEN : `FSR_CHIP_LEN;
		else if (gp)
		begin
			// RQ16: pins a..d in bytes four to seven
			if (i >= `FSR_IX_PIN_A && i <= `FSR_IX_PIN_D) b = {3'b000, p[i[1:0]]};
		end
		else
		begin
			unique case (i)
				// RQ5: bits one-zero read as zero
				`FSR_IX_CFG7: b = {1'b0, c.neg_en, c.pos_en, c.adc_ref, c.dac_supply, 2'b00};
				// RQ6: vendor id low first
				`FSR_IX_VID_LO: b = c.vid[7:0];
				`FSR_IX_VID_HI: b = c.vid[15:8];
				// RQ7: product id low first
				`FSR_IX_PID_LO: b = c.pid[7:0];
				`FSR_IX_PID_HI: b = c.pid[15:8];
				`FSR_IX_PWR: b = c.pwr_attr;
				`FSR_IX_MA: b = c.half_ma;
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction

	assign take = ce && req_valid && req_ready_q;
	assign rise = edge_sync_q[1] && !edge_sync_q[2];
	assign fall = !edge_sync_q[1] && edge_sync_q[2];

	// sequencer: apply once after reset, then serve reports
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= fsr_pkg::FSR_ST_APPLY;
			req_ready_q <= 1'b0;
			idx_q <= 6'h00;
			kind_q <= 1'b0;
		end
		else if (ce)
		begin
			unique case (state_q)
				// RQ18: no command taken before pins applied
				fsr_pkg::FSR_ST_APPLY:
				begin
					state_q <= fsr_pkg::FSR_ST_IDLE;
					req_ready_q <= 1'b1;
				end
				fsr_pkg::FSR_ST_IDLE:
				begin
					if (req_valid)
					begin
						state_q <= fsr_pkg::FSR_ST_SEND;
						req_ready_q <= 1'b0;
						idx_q <= 6'h00;
						kind_q <= req_gp;
					end
				end
				// RQ17: walk all 64 bytes
				fsr_pkg::FSR_ST_SEND:
				begin
					idx_q <= idx_q + 6'h01;
					if (idx_q == `FSR_LAST_IDX)
					begin
						state_q <= fsr_pkg::FSR_ST_IDLE;
						req_ready_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// response byte register; one byte per enabled cycle
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 8'h00;
			rsp_index_q <= 6'h00;
			rsp_last_q <= 1'b0;
		end
		else if (ce)
		begin
			rsp_valid_q <= state_q == fsr_pkg::FSR_ST_SEND;
			rsp_data_q <= rsp_byte(kind_q, idx_q, chip_cfg_i, pin_cfg_i);
			rsp_index_q <= idx_q;
			rsp_last_q <= state_q == fsr_pkg::FSR_ST_SEND && idx_q == `FSR_LAST_IDX;
		end
	end

	// chip-wide settings other than the edge enables latched once; later flash edits wait for reset
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			adc_ref_q <= fsr_pkg::FSR_REF_OFF;
			dac_ref_supply_q <= 1'b0;
			usb_pwr_attr_q <= 8'h00;
			usb_max_ma_q <= 9'h000;
		end
		else if (ce && state_q == fsr_pkg::FSR_ST_APPLY)
		begin
			// RQ4: reference code to choice
			adc_ref_q <= fsr_pkg::fsr_adc_ref_t'(chip_cfg_i.adc_ref);
			// RQ5: one selects the supply
			dac_ref_supply_q <= chip_cfg_i.dac_supply;
			// RQ8: enumeration attributes
			usb_pwr_attr_q <= chip_cfg_i.pwr_attr;
			// RQ9: twice stored current
			usb_max_ma_q <= {chip_cfg_i.half_ma, 1'b0};
		end
	end

	// per-pin role, drive and enable
	for (genvar g = 0; g < 4; g++)
	begin : gen_pin
		fsr_pkg::fsr_func_t fn_d;
		logic alt_d;
		always_comb
		begin
			// RQ13: roles for pin a
			// RQ14: roles for pin b
			// RQ15: roles for pin c
			fn_d = decode_fn(2'(g), pin_cfg_i[g].desig);
			unique case (pin_func_q[g])
				fsr_pkg::FSR_FN_SUSPEND: alt_d = alt_i.suspend;
				fsr_pkg::FSR_FN_URX: alt_d = alt_i.urx_act;
				fsr_pkg::FSR_FN_UTX: alt_d = alt_i.utx_act;
				fsr_pkg::FSR_FN_CLKREF: alt_d = alt_i.clk_ref;
				fsr_pkg::FSR_FN_USB_CONFIGURED_INDICATOR: alt_d = alt_i.usb_cfg;
				fsr_pkg::FSR_FN_I2C: alt_d = alt_i.i2c_act;
				default: alt_d = 1'b0;
			endcase
		end
		// role latched at apply; indicator roles follow their source
		always_ff @(posedge core_clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				pin_func_q[g] <= fsr_pkg::FSR_FN_NONE;
				general_pin_o_q[g] <= 1'b0;
				general_pin_oe_q[g] <= 1'b0;
			end
			else if (ce && state_q == fsr_pkg::FSR_ST_APPLY)
			begin
				pin_func_q[g] <= fn_d;
				// RQ10: stored level driven at power-up
				// RQ11: same for pins b and c
				general_pin_o_q[g] <= pin_cfg_i[g].out_level;
				// RQ12: direction only in general-purpose role
				general_pin_oe_q[g] <= fn_d == fsr_pkg::FSR_FN_GPIO && !pin_cfg_i[g].dir_in;
			end
			else if (ce && pin_func_q[g] != fsr_pkg::FSR_FN_GPIO)
			begin
				// ignored codes and analog roles leave the pad undriven
				general_pin_o_q[g] <= alt_d;
				general_pin_oe_q[g] <= pin_func_q[g] inside {fsr_pkg::FSR_FN_SUSPEND,
					fsr_pkg::FSR_FN_URX, fsr_pkg::FSR_FN_UTX, fsr_pkg::FSR_FN_CLKREF,
					fsr_pkg::FSR_FN_USB_CONFIGURED_INDICATOR, fsr_pkg::FSR_FN_I2C};
			end
		end
	end

	// pin b input synchroniser; only stages two and three are compared
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			edge_sync_q <= 3'b000;
		end
		else if (ce)
		begin
			edge_sync_q <= {edge_sync_q[1:0], general_pin_i[1]};
		end
	end

	// interrupt detection flag; a new edge beats a same-cycle clear
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			intr_flag_q <= 1'b0;
		end
		else if (ce)
		begin
			// RQ2: falling edge when enabled
			// RQ3: rising edge when enabled
			if (pin_func_q[1] == fsr_pkg::FSR_FN_EDGE
				&& ((fall && chip_cfg_i.neg_en) || (rise && chip_cfg_i.pos_en)))
			begin
				intr_flag_q <= 1'b1;
			end
			else if (intr_clear)
			begin
				intr_flag_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic sending;
	assign sending = ce && state_q == fsr_pkg::FSR_ST_SEND;
	property p_hdr;
		rsp_valid_q && rsp_index_q == `FSR_IX_CMD |-> rsp_data_q == `FSR_CMD_ECHO;
	endproperty
	a_hdr: assert property (p_hdr) else $error("command echo wrong"); // RQ1
	property p_sts;
		rsp_valid_q && rsp_index_q == `FSR_IX_STS |-> rsp_data_q == `FSR_STS_OK;
	endproperty
	a_sts: assert property (p_sts) else $error("status byte not zero"); // RQ1
	property p_neg;
		ce && fall && chip_cfg_i.neg_en && pin_func_q[1] == fsr_pkg::FSR_FN_EDGE |=> intr_flag_q;
	endproperty
	a_neg: assert property (p_neg) else $error("falling edge lost"); // RQ2
	property p_pos;
		ce && rise && chip_cfg_i.pos_en && pin_func_q[1] == fsr_pkg::FSR_FN_EDGE |=> intr_flag_q;
	endproperty
	a_pos: assert property (p_pos) else $error("rising edge lost"); // RQ3
	property p_adc;
		ce && state_q == fsr_pkg::FSR_ST_APPLY |=> adc_ref_q == $past(chip_cfg_i.adc_ref);
	endproperty
	a_adc: assert property (p_adc) else $error("reference select wrong"); // RQ4
	property p_vid;
		sending && !kind_q && idx_q == `FSR_IX_VID_LO |=> rsp_data_q == $past(chip_cfg_i.vid[7:0]);
	endproperty
	a_vid: assert property (p_vid) else $error("vendor low byte wrong"); // RQ6
	property p_pid;
		sending && !kind_q && idx_q == `FSR_IX_PID_HI |=> rsp_data_q == $past(chip_cfg_i.pid[15:8]);
	endproperty
	a_pid: assert property (p_pid) else $error("product high byte wrong"); // RQ7
	property p_ma;
		ce && state_q == fsr_pkg::FSR_ST_APPLY
			|=> usb_max_ma_q == {$past(chip_cfg_i.half_ma), 1'b0};
	endproperty
	a_ma: assert property (p_ma) else $error("current not doubled"); // RQ9
	property p_dir;
		ce && state_q == fsr_pkg::FSR_ST_APPLY && pin_cfg_i[0].desig == `FSR_DES_GPIO
			|=> general_pin_oe_q[0] == !$past(pin_cfg_i[0].dir_in);
	endproperty
	a_dir: assert property (p_dir) else $error("pin a direction wrong"); // RQ12
	property p_last;
		rsp_last_q |-> rsp_valid_q && rsp_index_q == `FSR_LAST_IDX;
	endproperty
	a_last: assert property (p_last) else $error("report not 64 bytes"); // RQ17
	property p_ready;
		req_ready_q |-> state_q == fsr_pkg::FSR_ST_IDLE;
	endproperty
	a_ready: assert property (p_ready) else $error("ready before apply"); // RQ18
	c_chip: cover property (take && !req_gp ##1 sending [*3]);
	c_gp: cover property (rsp_last_q && kind_q);
	c_intr: cover property (!intr_flag_q ##1 intr_flag_q);
endmodule

// *** test/fsr_host_model.sv ***
// host-side model: asks for a settings report and captures its bytes
`timescale 1ns/10ps
module fsr_host_model
(
	input wire logic core_clk,
	input wire logic ce,
	input wire logic req_ready_q,
	input wire logic rsp_valid_q,
	input wire logic [7:0] rsp_data_q,
	input wire logic [5:0] rsp_index_q,
	input wire logic rsp_last_q,
	output logic req_valid,
	output logic req_gp
);
	logic [7:0] rpt [64]; // captured report
	int n_bytes; // bytes taken in the last report
	logic got_last; // final byte seen
	initial
	begin
		req_valid = 1'b0;
		req_gp = 1'b0;
	end
	// a byte counts once, on the enabled edge that moves the block on
	always @(posedge core_clk)
	begin
		if (rsp_valid_q === 1'b1 && ce === 1'b1)
		begin
			rpt[rsp_index_q] <= rsp_data_q;
			n_bytes <= n_bytes + 1;
			if (rsp_last_q === 1'b1)
				got_last <= 1'b1;
		end
	end
	// request held until an edge sees ready, then the report is awaited
	task automatic read_report(input logic gp);
		int w;
		w = 0;
		n_bytes = 0;
		got_last = 1'b0;
		@(negedge core_clk);
		req_valid = 1'b1;
		req_gp = gp;
		@(posedge core_clk);
		while ((req_ready_q !== 1'b1 || ce !== 1'b1) && w < 50)
		begin
			@(posedge core_clk);
			w++;
		end
		@(negedge core_clk);
		req_valid = 1'b0;
		// select line released: show the opposite, never a stale value
		req_gp = ~gp;
		while (got_last !== 1'b1 && w < 300)
		begin
			@(posedge core_clk);
			w++;
		end
	endtask
endmodule

// *** test/fsr_top_bench.sv ***
// self-checking bench for the flash settings readback
`timescale 1ns/10ps
module fsr_top_bench;
	logic core_clk, arst_n, ce, intr_clear, req_valid, req_gp;
	fsr_pkg::fsr_chip_cfg_t chip_cfg; // stored chip settings
	fsr_pkg::fsr_pin_cfg_t [3:0] pin_cfg; // stored pin bytes
	fsr_pkg::fsr_alt_t alt; // indicator sources
	logic req_ready_q, rsp_valid_q, rsp_last_q, intr_flag_q, dac_ref_supply_q;
	logic [7:0] rsp_data_q, usb_pwr_attr_q;
	logic [5:0] rsp_index_q;
	logic [3:0] gp_in, gp_o, gp_oe, oe_exp, io_exp;
	fsr_pkg::fsr_func_t [3:0] pin_func;
	fsr_pkg::fsr_adc_ref_t adc_ref;
	logic [8:0] usb_max_ma_q;
	logic [7:0] exp_rpt [64]; // expected report
	int bad_count, n_tests;
	fsr_top i_dut
	(
		.core_clk, .arst_n, .ce, .chip_cfg_i(chip_cfg), .pin_cfg_i(pin_cfg), .alt_i(alt),
		.req_valid, .req_gp, .req_ready_q, .rsp_valid_q, .rsp_data_q, .rsp_index_q,
		.rsp_last_q, .general_pin_i(gp_in), .general_pin_o_q(gp_o), .general_pin_oe_q(gp_oe),
		.pin_func_q(pin_func), .intr_clear, .intr_flag_q, .adc_ref_q(adc_ref),
		.dac_ref_supply_q, .usb_pwr_attr_q, .usb_max_ma_q
	);
	fsr_host_model i_host
	(
		.core_clk, .ce, .req_ready_q, .rsp_valid_q, .rsp_data_q, .rsp_index_q,
		.rsp_last_q, .req_valid, .req_gp
	);
	// free-running 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// expected role of a pin for a stored code
	function automatic fsr_pkg::fsr_func_t role_exp(input int p, input int k);
		case (p * 8 + k)
			0, 8, 16, 24: role_exp = fsr_pkg::FSR_FN_GPIO;
			1: role_exp = fsr_pkg::FSR_FN_SUSPEND;
			2: role_exp = fsr_pkg::FSR_FN_URX;
			9: role_exp = fsr_pkg::FSR_FN_CLKREF;
			10: role_exp = fsr_pkg::FSR_FN_ANALOG_INPUT_ONE;
			11: role_exp = fsr_pkg::FSR_FN_UTX;
			12: role_exp = fsr_pkg::FSR_FN_EDGE;
			17: role_exp = fsr_pkg::FSR_FN_USB_CONFIGURED_INDICATOR;
			18: role_exp = fsr_pkg::FSR_FN_ANALOG_INPUT_TWO;
			19: role_exp = fsr_pkg::FSR_FN_ANALOG_OUTPUT_ONE;
			25: role_exp = fsr_pkg::FSR_FN_I2C;
			26: role_exp = fsr_pkg::FSR_FN_ADC3;
			27: role_exp = fsr_pkg::FSR_FN_DAC2;
			default: role_exp = fsr_pkg::FSR_FN_NONE;
		endcase
	endfunction
	task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask
	// reset held six cycles, released off the sampling edge
	task automatic do_reset();
		arst_n = 1'b0;
		repeat (6) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge core_clk);
	endtask
	task automatic chk_rpt(input string nm);
		for (int i = 0; i < 64; i++)
			cmp($sformatf("%s byte %0d", nm, i), {8'h00, exp_rpt[i]}, {8'h00, i_host.rpt[i]});
		cmp({nm, " count"}, 16'h0040, 16'(i_host.n_bytes));
		$display("test %s report done", nm);
	endtask
	// pad level change, flag check, then clear
	task automatic edge_step(input logic lvl, input logic flag);
		@(negedge core_clk);
		gp_in[1] = lvl;
		repeat (6) @(negedge core_clk);
		cmp("intr flag", {15'h0000, flag}, {15'h0000, intr_flag_q});
		intr_clear = 1'b1;
		@(negedge core_clk);
		intr_clear = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// watchdog: whole run needs well under a thousand cycles
	initial
	begin
		repeat (3000) @(posedge core_clk);
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		bad_count = 0;
		n_tests = 0;
		arst_n = 1'b0;
		ce = 1'b1;
		intr_clear = 1'b0;
		alt = '1;
		gp_in = 4'h0;
		chip_cfg = {1'h0, 1'h1, 2'h2, 1'h1, 16'ha1b2, 16'hc3d4, 8'h80, 8'h32};
		// every designation code on every pin, level 1 and output direction
		for (int k = 0; k < 8; k++)
		begin
			pin_cfg = {4{1'b1, 1'b0, 3'(k)}};
			chip_cfg.adc_ref = 2'(k);
			chip_cfg.dac_supply = k[0];
			do_reset();
			for (int p = 0; p < 4; p++)
			begin
				cmp("pin role", 16'(role_exp(p, k)), 16'(pin_func[p]));
				oe_exp[p] = role_exp(p, k) inside {fsr_pkg::FSR_FN_GPIO, fsr_pkg::FSR_FN_SUSPEND,
					fsr_pkg::FSR_FN_URX, fsr_pkg::FSR_FN_CLKREF, fsr_pkg::FSR_FN_UTX,
					fsr_pkg::FSR_FN_USB_CONFIGURED_INDICATOR, fsr_pkg::FSR_FN_I2C};
			end
			cmp("pin enable", 16'(oe_exp), 16'(gp_oe));
			cmp("pin drive", 16'(oe_exp), 16'(gp_o & oe_exp));
			cmp("adc ref", 16'(k[1:0]), 16'(adc_ref));
			cmp("dac ref", 16'(k[0]), 16'(dac_ref_supply_q));
			// indicator roles must follow their source, not the stored level
			alt = '0;
			repeat (2) @(negedge core_clk);
			for (int p = 0; p < 4; p++)
				io_exp[p] = role_exp(p, k) == fsr_pkg::FSR_FN_GPIO;
			cmp("pin follow", 16'(io_exp), 16'(gp_o & oe_exp));
			alt = '1;
		end
		$display("test designation codes done");
		// a gpio out high, b edge input, c analog out, d gpio input
		pin_cfg = {5'h18, 5'h03, 5'h0c, 5'h10};
		chip_cfg.adc_ref = 2'h2;
		chip_cfg.dac_supply = 1'h1;
		do_reset();
		cmp("base enable", 16'h0001, 16'(gp_oe));
		cmp("base drive", 16'h0001, 16'(gp_o & 4'h1));
		cmp("power attr", 16'h0080, 16'(usb_pwr_attr_q));
		cmp("max ma", 16'h0064, 16'(usb_max_ma_q));
		exp_rpt = '{default: 8'h00};
		exp_rpt[0] = 8'hb0;
		exp_rpt[2] = 8'h0e;
		exp_rpt[7] = 8'h34;
		exp_rpt[8] = 8'hb2;
		exp_rpt[9] = 8'ha1;
		exp_rpt[10] = 8'hd4;
		exp_rpt[11] = 8'hc3;
		exp_rpt[12] = 8'h80;
		exp_rpt[13] = 8'h32;
		i_host.read_report(1'b0);
		chk_rpt("chip");
		exp_rpt = '{default: 8'h00};
		exp_rpt[0] = 8'hb0;
		exp_rpt[2] = 8'h08;
		exp_rpt[4] = 8'h10;
		exp_rpt[5] = 8'h0c;
		exp_rpt[6] = 8'h03;
		exp_rpt[7] = 8'h18;
		// clock enable dropped mid-report: bytes must stall, not be lost
		fork
			i_host.read_report(1'b1);
			begin
				repeat (20) @(negedge core_clk);
				ce = 1'b0;
				repeat (3) @(negedge core_clk);
				ce = 1'b1;
			end
		join
		chk_rpt("pins");
		// rising enabled only, then falling enabled only
		edge_step(1'b1, 1'b1);
		edge_step(1'b0, 1'b0);
		chip_cfg.pos_en = 1'h0;
		chip_cfg.neg_en = 1'h1;
		edge_step(1'b1, 1'b0);
		edge_step(1'b0, 1'b1);
		$display("test edge flag done");
		report_and_stop();
	end
endmodule
